//--- common/gpio_pkg.sv
// gpio_pkg: register map, field layout and sense encodings for the pin group controller
// assumes an 8-bit register port with byte offsets as the address
package gpio_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // regular register offsets
  localparam logic [7:0] OFF_DIR = 8'h00;
  localparam logic [7:0] OFF_DRIVE_ENABLE_SET_STROBE = 8'h01;
  localparam logic [7:0] OFF_DRIVE_ENABLE_CLEAR_STROBE = 8'h02;
  localparam logic [7:0] OFF_DRIVE_ENABLE_TOGGLE_STROBE = 8'h03;
  localparam logic [7:0] OFF_OUT = 8'h04;
  localparam logic [7:0] OFF_DRIVE_VALUE_SET_STROBE = 8'h05;
  localparam logic [7:0] OFF_DRIVE_VALUE_CLEAR_STROBE = 8'h06;
  localparam logic [7:0] OFF_DRIVE_VALUE_TOGGLE_STROBE = 8'h07;
  localparam logic [7:0] OFF_IN = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h09;
  localparam logic [7:0] OFF_CFG0 = 8'h10;
  // fast alias block
  localparam logic [7:0] OFF_ALIAS_DIR = 8'h20;
  localparam logic [7:0] OFF_ALIAS_OUT = 8'h21;
  localparam logic [7:0] OFF_ALIAS_IN = 8'h22;
  localparam logic [7:0] OFF_ALIAS_FLAGS = 8'h23;
  // per_pin_config field layout
  localparam int CFG_FLIP_BIT = 7;
  localparam int CFG_BIAS_BIT = 3;
  localparam int CFG_SENSE_LSB = 0;
  localparam int SENSE_W = 3;
  localparam logic [7:0] CFG_MASK = 8'h8f;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  // sense_config encodings
  localparam logic [2:0] SENSE_NONE = 3'h0;
  localparam logic [2:0] SENSE_ANY_EDGE = 3'h1;
  localparam logic [2:0] SENSE_RISE = 3'h2;
  localparam logic [2:0] SENSE_FALL = 3'h3;
  localparam logic [2:0] SENSE_INPUT_OFF = 3'h4;
  localparam logic [2:0] SENSE_LOW = 3'h5;
  // dead time after an accepted synchronous event
  localparam int DEAD_CYCLES = 3;
  typedef enum logic [1:0] {
    DEAD_IDLE = 2'b00,
    DEAD_ONE = 2'b01,
    DEAD_TWO = 2'b11,
    DEAD_THREE = 2'b10
  } dead_type;
endpackage

//--- src/gpio_pin_controller.sv
// gpio_pin_controller: direction, drive value, synchronised input, per-pin config and events
// assumes pads outside resolve pin level from drive enable, value and bias
//
// Notes on behaviour
// R1: one group of up to eight pins, each with direction and drive bit.
// R2: direction bit one makes the pin output, zero makes it input.
// R3: direction-set strobe sets only the bits written as one.
// R4: direction-clear strobe clears only the bits written as one.
// R5: direction-toggle strobe inverts only the bits written as one.
// R6: drive-set strobe sets only the drive bits written as one.
// R7: drive-clear strobe clears only the drive bits written as one.
// R8: drive-toggle strobe or a write to input register inverts drive bits.
// R9: input register shows synchronised pins; synchroniser frozen while input disabled.
// R10: sampled level readable whatever the direction unless input disabled.
// R11: config for pin n sits at byte offset 0x10 plus n.
// R12: polarity flip inverts both input and output path of the pin.
// R13: changing polarity flip gives an edge seen by event sensing.
// R14: weak-high-bias bit one enables the pullup on the pin.
// R15: event condition chosen per pin: any edge, rise, fall, low, off.
// R16: after reset outputs tri-stated, input buffers enabled.
// R17: asynchronous sensing can request wake with no clock running.
// R18: async pins wake under any sense; others only any edge or low.
// R19: alias registers act exactly like the regular registers.
// R20: software should not change flip and sense in the same cycle.
// R21: an event pending at input disable may appear on re-enable.
// R22: a sense change while synchronising may drop the pending event.
// R23: synchronous path ignores new events for three cycles after one.
// R24: sense field three bits: none, any edge, rise, fall, off, low.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_controller
  import gpio_pkg::*;
#(
  parameter int PINS = 8,
  parameter logic [7:0] ASYNC_PINS = 8'h04
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // pads
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] pin_pullup,
  output logic [PINS-1:0] pin_in_enable,
  // events and wake
  output logic [PINS-1:0] external_event_line,
  output logic [PINS-1:0] wake_enable
);

  logic [PINS-1:0] dir_r;
  logic [PINS-1:0] out_r;
  logic [PINS-1:0] flags_r;
  logic [PINS-1:0] sync1_r;
  logic [PINS-1:0] sync2_r;
  logic [PINS-1:0] prev_r;
  logic [7:0] cfg_r [PINS];
  logic [PINS-1:0] flip;
  logic [PINS-1:0] in_off;
  logic [PINS-1:0] level;
  logic [PINS-1:0] hit;
  logic [PINS-1:0] accept;
  logic [DATA_W-1:0] rdata_nxt;
  logic [PINS-1:0] wmask;
  logic [PINS-1:0] one_edge;

  // R1 one write bit per pin
  assign wmask = wdata[PINS-1:0];

  // R19 alias decode, R3 R4 R5 direction strobes, R2 direction
  always_ff @(posedge clk) begin
    if (srst) begin
      dir_r <= '0;
    end else if (wr) begin
      case (addr)
        OFF_DIR, OFF_ALIAS_DIR: dir_r <= wmask;
        OFF_DRIVE_ENABLE_SET_STROBE: dir_r <= dir_r | wmask;
        OFF_DRIVE_ENABLE_CLEAR_STROBE: dir_r <= dir_r & ~wmask;
        OFF_DRIVE_ENABLE_TOGGLE_STROBE: dir_r <= dir_r ^ wmask;
        default: dir_r <= dir_r;
      endcase
    end
  end

  // R6 R7 R8 drive value strobes; write to input register toggles
  always_ff @(posedge clk) begin
    if (srst) begin
      out_r <= '0;
    end else if (wr) begin
      case (addr)
        OFF_OUT, OFF_ALIAS_OUT: out_r <= wmask;
        OFF_DRIVE_VALUE_SET_STROBE: out_r <= out_r | wmask;
        OFF_DRIVE_VALUE_CLEAR_STROBE: out_r <= out_r & ~wmask;
        OFF_DRIVE_VALUE_TOGGLE_STROBE, OFF_IN, OFF_ALIAS_IN: out_r <= out_r ^ wmask;
        default: out_r <= out_r;
      endcase
    end
  end

  // R11 per-pin config at 0x10 plus n, R24 three-bit sense field
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_ff @(posedge clk) begin
        if (srst) begin
          cfg_r[g] <= RESET_ZERO;
        end else if (wr && addr == OFF_CFG0 + ADDR_W'(g)) begin
          cfg_r[g] <= wdata & CFG_MASK;
        end
      end
      assign flip[g] = cfg_r[g][CFG_FLIP_BIT];
      assign in_off[g] = cfg_r[g][CFG_SENSE_LSB +: SENSE_W] == SENSE_INPUT_OFF;
      // R18 single-edge senses, which cannot wake a synchronous pin
      assign one_edge[g] = cfg_r[g][CFG_SENSE_LSB +: SENSE_W] == SENSE_RISE
                           || cfg_r[g][CFG_SENSE_LSB +: SENSE_W] == SENSE_FALL;
      // R12 R13 inversion after the synchroniser, so a flip change is an edge
      assign level[g] = sync2_r[g] ^ flip[g];
      // R15 R22 live sense field, a change mid-sync may drop an edge
      always_comb begin
        case (cfg_r[g][CFG_SENSE_LSB +: SENSE_W])
          SENSE_ANY_EDGE: hit[g] = level[g] ^ prev_r[g];
          SENSE_RISE: hit[g] = level[g] & ~prev_r[g];
          SENSE_FALL: hit[g] = ~level[g] & prev_r[g];
          SENSE_LOW: hit[g] = ~level[g];
          default: hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // R9 R21 synchroniser holds its state while input disabled
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (!in_off[i]) begin
          sync1_r[i] <= pin_in[i];
          sync2_r[i] <= sync1_r[i];
        end
      end
    end
  end

  // previous level for edge detection, frozen with the synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_r <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (!in_off[i]) begin
          prev_r[i] <= level[i];
        end
      end
    end
  end

  // R23 dead time per synchronous pin
  dead_type dead_r [PINS];
  generate
    for (g = 0; g < PINS; g++) begin : g_dead
      always_ff @(posedge clk) begin
        if (srst) begin
          dead_r[g] <= DEAD_IDLE;
        end else begin
          case (dead_r[g])
            DEAD_IDLE: dead_r[g] <= accept[g] ? DEAD_ONE : DEAD_IDLE;
            DEAD_ONE: dead_r[g] <= DEAD_TWO;
            DEAD_TWO: dead_r[g] <= DEAD_THREE;
            DEAD_THREE: dead_r[g] <= DEAD_IDLE;
            default: dead_r[g] <= DEAD_IDLE;
          endcase
        end
      end
      // async pins see no dead time
      assign accept[g] = hit[g] & (ASYNC_PINS[g] | dead_r[g] == DEAD_IDLE) & ~in_off[g];
    end
  endgenerate

  // event flags: hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_r <= '0;
    end else if (wr && (addr == OFF_FLAGS || addr == OFF_ALIAS_FLAGS)) begin
      flags_r <= (flags_r & ~wmask) | accept;
    end else begin
      flags_r <= flags_r | accept;
    end
  end

  // per-pin event strobe, one cycle per accepted event; stays high while an async pin senses low
  always_ff @(posedge clk) begin
    if (srst) begin
      external_event_line <= '0;
    end else begin
      external_event_line <= accept;
    end
  end

  // R16 R12 R14 pad controls: reset tri-states and keeps inputs enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_oe <= '0;
      pin_out <= '0;
      pin_pullup <= '0;
      pin_in_enable <= '1;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        pin_oe[i] <= dir_r[i];
        pin_out[i] <= out_r[i] ^ flip[i];
        pin_pullup[i] <= cfg_r[i][CFG_BIAS_BIT];
        pin_in_enable[i] <= ~in_off[i];
      end
    end
  end

  // R17 R18 wake qualification; the pad-side async detector uses this level
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_enable <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        case (cfg_r[i][CFG_SENSE_LSB +: SENSE_W])
          SENSE_ANY_EDGE, SENSE_LOW: wake_enable[i] <= 1'b1;
          SENSE_RISE, SENSE_FALL: wake_enable[i] <= ASYNC_PINS[i];
          default: wake_enable[i] <= 1'b0;
        endcase
      end
    end
  end

  // R10 read mux; input visible in any direction
  always_comb begin
    rdata_nxt = '0;
    case (addr)
      OFF_DIR, OFF_DRIVE_ENABLE_SET_STROBE, OFF_DRIVE_ENABLE_CLEAR_STROBE, OFF_DRIVE_ENABLE_TOGGLE_STROBE, OFF_ALIAS_DIR: rdata_nxt = DATA_W'(dir_r);
      OFF_OUT, OFF_DRIVE_VALUE_SET_STROBE, OFF_DRIVE_VALUE_CLEAR_STROBE, OFF_DRIVE_VALUE_TOGGLE_STROBE, OFF_ALIAS_OUT: rdata_nxt = DATA_W'(out_r);
      OFF_IN, OFF_ALIAS_IN: rdata_nxt = DATA_W'(level);
      OFF_FLAGS, OFF_ALIAS_FLAGS: rdata_nxt = DATA_W'(flags_r);
      default: begin
        for (int i = 0; i < PINS; i++) begin
          if (addr == OFF_CFG0 + ADDR_W'(i)) begin
            rdata_nxt = cfg_r[i];
          end
        end
      end
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rdata_nxt : '0;
    end
  end

  // R3 set strobe leaves other bits
  property p_drive_enable_set_strobe;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_DRIVE_ENABLE_SET_STROBE) |=> dir_r == ($past(dir_r) | $past(wmask));
  endproperty
  a_drive_enable_set_strobe: assert property (p_drive_enable_set_strobe) else $error("dir set wrong"); // R3

  property p_drive_enable_clear_strobe;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_DRIVE_ENABLE_CLEAR_STROBE) |=> dir_r == ($past(dir_r) & ~$past(wmask));
  endproperty
  a_drive_enable_clear_strobe: assert property (p_drive_enable_clear_strobe) else $error("dir clear wrong"); // R4

  property p_drive_enable_toggle_strobe;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_DRIVE_ENABLE_TOGGLE_STROBE) |=> dir_r == ($past(dir_r) ^ $past(wmask));
  endproperty
  a_drive_enable_toggle_strobe: assert property (p_drive_enable_toggle_strobe) else $error("dir toggle wrong"); // R5

  property p_drive_value_set_strobe;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_DRIVE_VALUE_SET_STROBE) |=> out_r == ($past(out_r) | $past(wmask));
  endproperty
  a_drive_value_set_strobe: assert property (p_drive_value_set_strobe) else $error("out set wrong"); // R6

  property p_drive_value_clear_strobe;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_DRIVE_VALUE_CLEAR_STROBE) |=> out_r == ($past(out_r) & ~$past(wmask));
  endproperty
  a_drive_value_clear_strobe: assert property (p_drive_value_clear_strobe) else $error("out clear wrong"); // R7

  property p_intgl;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_IN) |=> out_r == ($past(out_r) ^ $past(wmask));
  endproperty
  a_intgl: assert property (p_intgl) else $error("in write toggle wrong"); // R8

  property p_oe;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_DIR) |=> ##1 pin_oe == $past(wmask, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("drive enable not following dir"); // R2

  property p_dead;
    @(posedge clk) disable iff (srst)
      (accept[0] && !ASYNC_PINS[0]) |=> !accept[0] [*3];
  endproperty
  a_dead: assert property (p_dead) else $error("event inside dead time"); // R23

  property p_rst;
    @(posedge clk) srst |=> (pin_oe == '0 && pin_in_enable == '1);
  endproperty
  a_rst: assert property (p_rst) else $error("reset pad state wrong"); // R16

  property p_flag_set;
    @(posedge clk) disable iff (srst)
      accept != '0 |=> (flags_r & $past(accept)) == $past(accept);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag lost to clear"); // R15

  property p_flag_clr;
    @(posedge clk) disable iff (srst)
      (wr && (addr == OFF_FLAGS || addr == OFF_ALIAS_FLAGS))
        |=> (flags_r & $past(wmask) & ~$past(accept)) == '0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear ignored"); // R19

  property p_in_off;
    @(posedge clk) disable iff (srst)
      in_off != '0 |=> (sync2_r & $past(in_off)) == ($past(sync2_r) & $past(in_off));
  endproperty
  a_in_off: assert property (p_in_off) else $error("synchroniser moved while disabled"); // R9

  property p_in_en;
    @(posedge clk) disable iff (srst)
      in_off != '0 |=> (pin_in_enable & $past(in_off)) == '0;
  endproperty
  a_in_en: assert property (p_in_en) else $error("input buffer left on while disabled"); // R9

  property p_wake_sync;
    @(posedge clk) disable iff (srst)
      one_edge != '0 |=> (wake_enable & $past(one_edge) & ~ASYNC_PINS[PINS-1:0]) == '0;
  endproperty
  a_wake_sync: assert property (p_wake_sync) else $error("sync pin wakes on one edge"); // R18

  property p_wake_any;
    @(posedge clk) disable iff (srst)
      (cfg_r[0][CFG_SENSE_LSB +: SENSE_W] == SENSE_ANY_EDGE) |=> wake_enable[0];
  endproperty
  a_wake_any: assert property (p_wake_any) else $error("any edge sense cannot wake"); // R18

  property p_cfg0;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_CFG0) |=> cfg_r[0] == ($past(wdata) & CFG_MASK);
  endproperty
  a_cfg0: assert property (p_cfg0) else $error("config write missed its pin"); // R11

  property p_pullup0;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_CFG0) |=> ##1 pin_pullup[0] == $past(wdata[CFG_BIAS_BIT], 2);
  endproperty
  a_pullup0: assert property (p_pullup0) else $error("pullup not following bias bit"); // R14

  property p_flip0;
    @(posedge clk) disable iff (srst)
      (wr && addr == OFF_CFG0)
        |=> ##1 pin_out[0] == ($past(out_r[0], 2) ^ $past(wdata[CFG_FLIP_BIT], 2));
  endproperty
  a_flip0: assert property (p_flip0) else $error("drive value not inverted by flip"); // R12

  property p_alias_rd;
    @(posedge clk) disable iff (srst)
      (rd && addr == OFF_ALIAS_DIR) |=> rdata == DATA_W'($past(dir_r));
  endproperty
  a_alias_rd: assert property (p_alias_rd) else $error("alias read differs"); // R19

endmodule // gpio_pin_controller
`default_nettype wire

//--- test/gpio_pad_model.sv
// gpio_pad_model: pad ring of one pin group with an outside driver
// assumes one clock; a pad left undriven and unpulled wanders every cycle
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_model (
  // clock
  input wire logic clk,
  // controller side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  // outside driver
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] level
);
  logic [7:0] float_r = 8'h5a;
  // floating pads must never look like a stable last value
  always @(posedge clk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) level[i] = pin_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pin_pullup[i]) level[i] = 1'b1;
      else level[i] = float_r[i];
    end
  end
endmodule // gpio_pad_model
`default_nettype wire

//--- test/gpio_pin_controller_bench.sv
// gpio_pin_controller_bench: directed scenarios for the pin group controller
// assumes gpio_pad_model at the pads and a single 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_controller_bench
  import gpio_pkg::*;
();
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] rdata, pin_in, pin_out, pin_oe, pin_pullup, pin_in_enable, ev, wake, d;
  logic [7:0] sense_tab [8] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h05, 8'h00, 8'h04, 8'h01};
  logic [7:0] ev_exp [8] = '{8'h02, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  int ev_cnt [8];
  int num_errors = 0;
  int total_checks = 0;
  // 50 ns period
  always #25 clk = ~clk;
  gpio_pin_controller #(.PINS(8), .ASYNC_PINS(8'h04)) i_dut (.clk(clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .pin_in_enable(pin_in_enable), .external_event_line(ev), .wake_enable(wake));
  gpio_pad_model i_pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .level(pin_in));
  // event pulses last one cycle, so count them at every edge
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (ev[i] === 1'b1) ev_cnt[i]++;
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    check(what, exp, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    check("oe", 8'h00, pin_oe);
    check("out", 8'h00, pin_out);
    check("in_en", 8'hff, pin_in_enable);
    rchk("dir", OFF_DIR, 8'h00);
    rchk("unmapped", 8'h0a, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_dir();
    wr_reg(OFF_DIR, 8'h0f);
    wr_reg(OFF_DRIVE_ENABLE_SET_STROBE, 8'h30);
    rchk("drive_enable_set_strobe", OFF_DRIVE_ENABLE_SET_STROBE, 8'h3f);
    wr_reg(OFF_DRIVE_ENABLE_CLEAR_STROBE, 8'h03);
    rchk("drive_enable_clear_strobe", OFF_DRIVE_ENABLE_CLEAR_STROBE, 8'h3c);
    wr_reg(OFF_DRIVE_ENABLE_TOGGLE_STROBE, 8'h81);
    rchk("drive_enable_toggle_strobe", OFF_ALIAS_DIR, 8'hbd);
    settle(2);
    check("oe", 8'hbd, pin_oe);
    wr_reg(OFF_ALIAS_DIR, 8'h80);
    settle(2);
    check("oe_alias", 8'h80, pin_oe);
    $display("test direction done");
  endtask
  task automatic t_out();
    wr_reg(OFF_OUT, 8'h0f);
    wr_reg(OFF_DRIVE_VALUE_SET_STROBE, 8'h30);
    rchk("drive_value_set_strobe", OFF_OUT, 8'h3f);
    wr_reg(OFF_DRIVE_VALUE_CLEAR_STROBE, 8'h03);
    rchk("drive_value_clear_strobe", OFF_OUT, 8'h3c);
    wr_reg(OFF_DRIVE_VALUE_TOGGLE_STROBE, 8'h81);
    wr_reg(OFF_IN, 8'h0c);
    rchk("in_tgl", OFF_ALIAS_OUT, 8'hb1);
    wr_reg(OFF_ALIAS_IN, 8'h31);
    settle(2);
    check("out", 8'h80, pin_out);
    $display("test drive value done");
  endtask
  task automatic t_input();
    ext_en <= 8'h5f;
    ext_val <= 8'h0a;
    wr_reg(OFF_CFG0 + 8'h05, 8'h08);
    settle(4);
    check("pullup", 8'h20, pin_pullup);
    rchk("in", OFF_IN, 8'haa);
    wr_reg(OFF_CFG0 + 8'h07, 8'hf0);
    wr_reg(OFF_CFG0 + 8'h01, 8'h80);
    settle(4);
    check("out_flip", 8'h02, pin_out);
    rchk("in_flip", OFF_ALIAS_IN, 8'ha8);
    rchk("cfg7", OFF_CFG0 + 8'h07, 8'h80);
    wr_reg(OFF_CFG0 + 8'h01, 8'h00);
    wr_reg(OFF_CFG0 + 8'h05, 8'h00);
    $display("test input done");
  endtask
  task automatic t_events();
    wr_reg(OFF_CFG0, 8'h01);
    settle(4);
    ev_cnt = '{default: 0};
    // flip written apart from the sense change
    wr_reg(OFF_CFG0, 8'h81);
    settle(6);
    check("flip_edge", 8'h01, 8'(ev_cnt[0]));
    for (int i = 0; i < 8; i++) wr_reg(OFF_CFG0 + 8'(i), sense_tab[i]);
    ext_en <= 8'h7f;
    ext_val <= 8'h00;
    settle(8);
    check("wake", 8'h95, wake);
    check("in_en", 8'hbf, pin_in_enable);
    ev_cnt = '{default: 0};
    ext_val <= 8'h7f;
    settle(8);
    ext_val <= 8'h00;
    settle(8);
    for (int i = 0; i < 8; i++) if (i != 4) check("events", ev_exp[i], 8'(ev_cnt[i]));
    check("low", 8'h01, 8'(ev_cnt[4] != 0));
    ev_cnt = '{default: 0};
    @(posedge clk);
    ext_val <= 8'h01;
    @(posedge clk);
    ext_val <= 8'h00;
    settle(8);
    check("dead", 8'h01, 8'(ev_cnt[0]));
    $display("test events done");
  endtask
  // low sense on pin 4 is stopped first, or it would refill its flag
  task automatic t_flags();
    wr_reg(OFF_CFG0 + 8'h04, 8'h00);
    wr_reg(OFF_FLAGS, 8'hff);
    rchk("flags_clr", OFF_FLAGS, 8'h00);
    ext_val <= 8'h04;
    settle(4);
    rchk("flags_rise", OFF_ALIAS_FLAGS, 8'h04);
    wr_reg(OFF_ALIAS_FLAGS, 8'h04);
    rchk("flags_alias_clr", OFF_FLAGS, 8'h00);
    ext_val <= 8'h00;
    $display("test flags done");
  endtask
  // bound on the whole run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    settle(1);
    t_reset();
    t_dir();
    t_out();
    t_input();
    t_events();
    t_flags();
    summarize();
  end
endmodule // gpio_pin_controller_bench
`default_nettype wire
